// file: design/flexible_second_operand_consts.vh
// Purpose: shared constants for the second-operand datapath and alignment check
// Assumes: included by bare name from design files only
// Notes: definitions only, no logic
//
// Behaviour
// - immediate expander yields any 8-bit value shifted anywhere in the word
// - immediate expander yields replicated-byte patterns in bytes 0/2, 1/3 or all
// - flagged logical ops with shifted-byte immediate above 255 load carry from bit 31
// - other immediate forms leave the carry flag unchanged
// - shifter supports arithmetic, logical, rotate shifts and one-bit rotate through carry
// - no shift or left shift by zero passes the source value unchanged
// - shifted result feeds the instruction, source register contents stay untouched
// - zero-length shift leaves carry alone, any nonzero shift updates it
// - arithmetic right shift fills the top n bits with the sign bit
// - arithmetic right carry is bit n-1, sign bit for n of 32 or more
// - logical right fills zeros, carry bit n-1, zero result from 32, zero carry from 33
// - logical left fills zeros, carry bit 32-n, zero result from 32, zero carry from 33
// - rotate right carry bit n-1, by 32 returns source, over 32 acts as n-32
// - rotate through carry inserts carry at bit 31, carry loads from bit 0
// - carry updates only for flagged shift or flagged logical and test instructions
// - word, dual and multiple need word alignment, halfword half alignment, byte always
// - unaligned allowed only for word, halfword and signed halfword loads and stores
// - any other unaligned load or store raises a usage fault instead of completing

`ifndef FLEXIBLE_SECOND_OPERAND_CONSTS_VH
`define FLEXIBLE_SECOND_OPERAND_CONSTS_VH

// shift type codes
`define SH_LSL          3'h0
`define SH_LSR          3'h1
`define SH_ASR          3'h2
`define SH_ROR          3'h3
`define SH_RRX          3'h4

// access size codes
`define SZ_BYTE         3'h0
`define SZ_HALF         3'h1
`define SZ_WORD         3'h2
`define SZ_DUAL         3'h3
`define SZ_MULTI        3'h4

// encoded immediate fields
`define IMM_MODE_HI     11
`define IMM_MODE_LO     10
`define IMM_PAT_HI      9
`define IMM_PAT_LO      8
`define IMM_ROT_HI      11
`define IMM_ROT_LO      7
`define IMM_LOW_HI      6
`define IMM_BYTE_HI     7
`define IMM_BYTE_LO     0

// replicated patterns
`define PAT_PLAIN       2'h0
`define PAT_EVEN        2'h1
`define PAT_ODD         2'h2
`define PAT_ALL         2'h3

// word layout
`define WORD_MSB        31
`define WORD_BITS       32
`define ZERO_WORD       32'h0000_0000
`define ADDR_LO_BITS    2'h0

`endif

// file: design/barrel_shift_unit.v
// Purpose: combinational barrel shifter for the register form of the second operand
// Assumes: amount is the full shift length, not limited to the immediate range
// Notes: result, carry and nonzero-amount flag only; the caller decides whether carry is written
`timescale 1ns/1ps
`include "flexible_second_operand_consts.vh"

module barrel_shift_unit #(
	parameter AMT_W = 8
) (
	input  wire [31:0]      src_value,
	input  wire [2:0]       shift_type,
	input  wire [AMT_W-1:0] shift_amount,
	input  wire             carry_in,
	output reg  [31:0]      shift_result,
	output reg              shift_carry,
	output reg              shift_nonzero
);

	reg        [32:0] wide;
	reg signed [32:0] swide;
	reg        [4:0]  rot;

	always @* begin
		wide          = 33'h0_0000_0000;
		swide         = 33'sh0_0000_0000;
		rot           = shift_amount[4:0];
		shift_result  = src_value;
		shift_carry   = carry_in;
		shift_nonzero = (shift_amount != {AMT_W{1'b0}});
		case (shift_type)
		`SH_LSL: begin
			wide         = {1'b0, src_value} << shift_amount;
			if (shift_nonzero) begin
				shift_result = wide[31:0];
				shift_carry  = wide[32];
			end
		end
		`SH_LSR: begin
			wide         = {src_value, 1'b0} >> shift_amount;
			if (shift_nonzero) begin
				shift_result = wide[32:1];
				shift_carry  = wide[0];
			end
		end
		`SH_ASR: begin
			swide = $signed({src_value, 1'b0});
			if (shift_amount >= `WORD_BITS)
				swide = swide >>> `WORD_BITS;
			else
				swide = swide >>> shift_amount;
			if (shift_nonzero) begin
				shift_result = swide[32:1];
				shift_carry  = swide[0];
			end
		end
		`SH_ROR: begin
			if (shift_nonzero) begin
				shift_result = (src_value >> rot) | (src_value << (6'd32 - {1'b0, rot}));
				shift_carry  = shift_result[`WORD_MSB];
			end
		end
		`SH_RRX: begin
			shift_result  = {carry_in, src_value[31:1]};
			shift_carry   = src_value[0];
			shift_nonzero = 1'b1;
		end
		default: begin
			shift_result  = src_value;
			shift_carry   = carry_in;
			shift_nonzero = 1'b0;
		end
		endcase
	end

endmodule // barrel_shift_unit

// file: design/flexible_second_operand_shifter_align_check.v
// Purpose: second-operand former, carry update decision and access alignment check
// Assumes: all inputs come from decode logic on sys_clk, no synchronisers needed
// Notes: one register stage on every output; srst is synchronous, active high
`timescale 1ns/1ps
`include "flexible_second_operand_consts.vh"

module flexible_second_operand_shifter_align_check #(
	parameter AMT_W  = 8,
	parameter ADDR_W = 32
) (
	input  wire              sys_clk,
	input  wire              srst,
	// operand request
	input  wire              op_valid,
	input  wire              op_use_imm,
	input  wire [11:0]       op_imm12,
	input  wire [31:0]       shift_source_register,
	input  wire [2:0]        shift_type,
	input  wire [AMT_W-1:0]  shift_amount,
	input  wire              carry_flag,
	input  wire              shift_insn_flags,
	input  wire              logic_insn_flags,
	// operand answer
	output reg               operand_valid,
	output reg  [31:0]       flexible_second_operand,
	output reg               carry_out,
	output reg               carry_write_enable,
	// access check request
	input  wire              mem_valid,
	input  wire [ADDR_W-1:0] mem_addr,
	input  wire [2:0]        mem_size,
	input  wire              mem_unaligned_ok,
	input  wire              unaligned_trap_enable,
	// access check answer
	output reg               access_valid,
	output reg               access_aligned,
	output reg               access_proceed,
	output reg               usage_fault_exception,
	output reg  [ADDR_W-1:0] fault_address
);

	// rotate right helper for the immediate expander
	function [31:0] ror32;
		input [31:0] value;
		input [4:0]  amount;
		begin
			ror32 = (value >> amount) | (value << (6'd32 - {1'b0, amount}));
		end
	endfunction

	// alignment test by access size
	function aligned_for;
		input [2:0] size;
		input [1:0] lo;
		begin
			case (size)
			`SZ_BYTE:  aligned_for = 1'b1;
			`SZ_HALF:  aligned_for = (lo[0] == 1'b0);
			`SZ_WORD,
			`SZ_DUAL,
			`SZ_MULTI: aligned_for = (lo == `ADDR_LO_BITS);
			default:   aligned_for = (lo == `ADDR_LO_BITS);
			endcase
		end
	endfunction

	// immediate expander
	reg  [7:0]  imm_byte;
	reg  [31:0] imm_value;
	reg         imm_is_rotated;
	reg  [31:0] imm_unrotated;

	always @* begin
		imm_byte       = op_imm12[`IMM_BYTE_HI:`IMM_BYTE_LO];
		imm_unrotated  = {24'h00_0000, 1'b1, op_imm12[`IMM_LOW_HI:0]};
		imm_is_rotated = (op_imm12[`IMM_MODE_HI:`IMM_MODE_LO] != 2'h0);
		imm_value      = `ZERO_WORD;
		if (imm_is_rotated) begin
			imm_value = ror32(imm_unrotated, op_imm12[`IMM_ROT_HI:`IMM_ROT_LO]);
		end else begin
			case (op_imm12[`IMM_PAT_HI:`IMM_PAT_LO])
			`PAT_PLAIN: imm_value = {24'h00_0000, imm_byte};
			`PAT_EVEN:  imm_value = {8'h00, imm_byte, 8'h00, imm_byte};
			`PAT_ODD:   imm_value = {imm_byte, 8'h00, imm_byte, 8'h00};
			`PAT_ALL:   imm_value = {imm_byte, imm_byte, imm_byte, imm_byte};
			default:    imm_value = {24'h00_0000, imm_byte};
			endcase
		end
	end

	// register form through the barrel shifter
	wire [31:0] sh_result;
	wire        sh_carry;
	wire        sh_nonzero;

	barrel_shift_unit #(
		.AMT_W         (AMT_W)
	) u_shift (
		.src_value     (shift_source_register),
		.shift_type    (shift_type),
		.shift_amount  (shift_amount),
		.carry_in      (carry_flag),
		.shift_result  (sh_result),
		.shift_carry   (sh_carry),
		.shift_nonzero (sh_nonzero)
	);

	// operand selection and carry decision
	reg  [31:0] next_operand;
	reg         next_carry;
	reg         next_carry_we;
	wire        carry_path;

	// flagged shift instructions, or flagged move, logical and test users
	assign carry_path = shift_insn_flags | logic_insn_flags;

	always @* begin
		next_operand  = `ZERO_WORD;
		next_carry    = carry_flag;
		next_carry_we = 1'b0;
		if (op_use_imm) begin
			next_operand = imm_value;
			if (imm_is_rotated) begin
				// rotated byte always exceeds 255
				next_carry    = imm_value[`WORD_MSB];
				next_carry_we = logic_insn_flags;
			end else begin
				next_carry    = carry_flag;
				next_carry_we = 1'b0;
			end
		end else begin
			next_operand = sh_result;
			if (sh_nonzero) begin
				next_carry    = sh_carry;
				next_carry_we = carry_path;
			end else begin
				next_carry    = carry_flag;
				next_carry_we = 1'b0;
			end
		end
		if (!op_valid) begin
			next_carry_we = 1'b0;
		end
	end

	// operand output stage
	always @(posedge sys_clk) begin
		if (srst) begin
			operand_valid           <= 1'b0;
			flexible_second_operand <= `ZERO_WORD;
			carry_out               <= 1'b0;
			carry_write_enable      <= 1'b0;
		end else begin
			operand_valid           <= op_valid;
			carry_write_enable      <= next_carry_we;
			if (op_valid) begin
				flexible_second_operand <= next_operand;
				carry_out               <= next_carry;
			end
		end
	end

	// alignment classification
	wire        next_aligned;
	wire        next_permit;
	wire        next_fault;

	assign next_aligned = aligned_for(mem_size, mem_addr[1:0]);

	// permitted kinds pass unaligned unless the trap is enabled
	assign next_permit = mem_unaligned_ok & ~unaligned_trap_enable;

	assign next_fault = mem_valid & ~next_aligned & ~next_permit;

	// access output stage
	always @(posedge sys_clk) begin
		if (srst) begin
			access_valid          <= 1'b0;
			access_aligned        <= 1'b0;
			access_proceed        <= 1'b0;
			usage_fault_exception <= 1'b0;
			fault_address         <= {ADDR_W{1'b0}};
		end else begin
			access_valid          <= mem_valid;
			usage_fault_exception <= next_fault;
			access_proceed        <= mem_valid & ~next_fault;
			if (mem_valid) begin
				access_aligned <= next_aligned;
			end
			if (next_fault) begin
				fault_address <= mem_addr;
			end
		end
	end

endmodule // flexible_second_operand_shifter_align_check

// file: test/flexible_second_operand_checker_asserts.sv
// Purpose: port checks for the operand former and alignment check
// Assumes: sees only top-level ports, one clock domain
// Notes: bound to the design at the file foot
`timescale 1ns/1ps
module flexible_second_operand_checker #(
	parameter AMT_W  = 8,
	parameter ADDR_W = 32
) (
	input wire             sys_clk,
	input wire             srst,
	input wire             op_valid,
	input wire             op_use_imm,
	input wire [11:0]      op_imm12,
	input wire [31:0]      shift_source_register,
	input wire [2:0]       shift_type,
	input wire [AMT_W-1:0] shift_amount,
	input wire             shift_insn_flags,
	input wire             logic_insn_flags,
	input wire             operand_valid,
	input wire [31:0]      flexible_second_operand,
	input wire             carry_out,
	input wire             carry_write_enable,
	input wire             mem_valid,
	input wire [2:0]       mem_size,
	input wire             access_valid,
	input wire             access_aligned,
	input wire             access_proceed,
	input wire             usage_fault_exception
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	wire reg_op = op_valid && !op_use_imm;
	imm_carry_a: assert property (
		op_valid && op_use_imm && op_imm12[11:10] != 2'h0 && logic_insn_flags
		|=> carry_write_enable && carry_out == flexible_second_operand[31])
		else $error("imm carry");
	pat_keep_a: assert property (
		op_valid && op_use_imm && op_imm12[11:10] == 2'h0
		|=> !carry_write_enable) else $error("pattern wrote carry");
	pass_thru_a: assert property (
		reg_op && shift_type == 3'h0 && shift_amount == 0
		|=> flexible_second_operand == $past(shift_source_register) && !carry_write_enable)
		else $error("no-shift value");
	asr_sign_a: assert property (
		reg_op && shift_type == 3'h2 && shift_amount >= 32
		|=> flexible_second_operand == {32{$past(shift_source_register[31])}})
		else $error("asr fill");
	lsr_zero_a: assert property (
		reg_op && shift_type == 3'h1 && shift_amount >= 32
		|=> flexible_second_operand == 32'h0000_0000) else $error("lsr result");
	lsl_carry_a: assert property (
		reg_op && shift_type == 3'h0 && shift_amount >= 33 && shift_insn_flags
		|=> carry_write_enable && !carry_out) else $error("lsl carry");
	no_flags_a: assert property (
		op_valid && !shift_insn_flags && !logic_insn_flags
		|=> operand_valid && !carry_write_enable) else $error("carry written");
	byte_ok_a: assert property (
		mem_valid && mem_size == 3'h0
		|=> access_aligned && access_proceed && !usage_fault_exception) else $error("byte");
	fault_stop_a: assert property (
		usage_fault_exception
		|-> access_valid && !access_proceed && !access_aligned) else $error("fault");
	we_pulse_a: assert property (
		carry_write_enable |-> operand_valid && $past(op_valid)
		&& ($past(shift_insn_flags) || $past(logic_insn_flags))) else $error("we pulse");
	fault_c: cover property (usage_fault_exception);
	imm_c: cover property (op_valid && op_use_imm ##1 carry_write_enable);
	big_shift_c: cover property (reg_op && shift_amount >= 33);
endmodule // flexible_second_operand_checker

bind flexible_second_operand_shifter_align_check flexible_second_operand_checker #(.AMT_W(AMT_W), .ADDR_W(ADDR_W)) i_chk (
	.sys_clk, .srst, .op_valid, .op_use_imm, .op_imm12, .shift_source_register, .shift_type,
	.shift_amount, .shift_insn_flags, .logic_insn_flags, .operand_valid, .flexible_second_operand,
	.carry_out, .carry_write_enable, .mem_valid, .mem_size, .access_valid, .access_aligned,
	.access_proceed, .usage_fault_exception);

// file: test/flexible_second_operand_shifter_align_check_tb.sv
// Purpose: directed bench for operand former and alignment check
// Assumes: one-cycle registered answers
// Notes: expectations worked by hand per case
`timescale 1ns/1ps
module flexible_second_operand_shifter_align_check_tb;
	reg         sys_clk, srst, op_valid, op_use_imm, carry_flag, shift_insn_flags;
	reg         logic_insn_flags, mem_valid, mem_unaligned_ok, unaligned_trap_enable;
	reg  [11:0] op_imm12;
	reg  [31:0] shift_source_register, mem_addr;
	reg  [2:0]  shift_type, mem_size;
	reg  [7:0]  shift_amount;
	wire        operand_valid, carry_out, carry_write_enable, access_valid;
	wire        access_aligned, access_proceed, usage_fault_exception;
	wire [31:0] flexible_second_operand, fault_address;
	integer     n_errors, checked;
	localparam [31:0] S = 32'h8000_0003;
	flexible_second_operand_shifter_align_check i_dut (.sys_clk, .srst, .op_valid, .op_use_imm, .op_imm12,
		.shift_source_register, .shift_type, .shift_amount, .carry_flag, .shift_insn_flags,
		.logic_insn_flags, .operand_valid, .flexible_second_operand, .carry_out,
		.carry_write_enable, .mem_valid, .mem_addr, .mem_size, .mem_unaligned_ok,
		.unaligned_trap_enable, .access_valid, .access_aligned, .access_proceed,
		.usage_fault_exception, .fault_address);
	task cmp_w(input [31:0] got, input [31:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("wrong value at %0t: word %h not %h", $time, got, exp);
			end
		end
	endtask
	task cmp_b(input got, input exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("wrong value at %0t: flag %b not %b", $time, got, exp);
			end
		end
	endtask
	task opr(input u, input [11:0] i, input [31:0] s, input [2:0] t, input [7:0] a,
		input c, input [1:0] f, input [31:0] eo, input ec, input ew);
		begin
			@(posedge sys_clk);
			op_valid <= 1'b1;
			op_use_imm <= u;
			op_imm12 <= i;
			shift_source_register <= s;
			shift_type <= t;
			shift_amount <= a;
			carry_flag <= c;
			{shift_insn_flags, logic_insn_flags} <= f;
			@(posedge sys_clk);
			op_valid <= 1'b0;
			#1;
			cmp_b(operand_valid, 1'b1);
			cmp_w(flexible_second_operand, eo);
			cmp_b(carry_out, ec);
			cmp_b(carry_write_enable, ew);
			@(posedge sys_clk);
			#1;
			cmp_b(operand_valid, 1'b0);
			cmp_b(carry_write_enable, 1'b0);
			cmp_w(flexible_second_operand, eo);
			cmp_b(carry_out, ec);
		end
	endtask
	task mchk(input [31:0] a, input [2:0] z, input ok, input trap, input eal, input ef);
		begin
			@(posedge sys_clk);
			mem_valid <= 1'b1;
			mem_addr <= a;
			mem_size <= z;
			mem_unaligned_ok <= ok;
			unaligned_trap_enable <= trap;
			@(posedge sys_clk);
			mem_valid <= 1'b0;
			#1;
			cmp_b(access_valid, 1'b1);
			cmp_b(access_aligned, eal);
			cmp_b(usage_fault_exception, ef);
			cmp_b(access_proceed, !ef);
			if (ef)
				cmp_w(fault_address, a);
			@(posedge sys_clk);
			#1;
			cmp_b(access_valid, 1'b0);
			cmp_b(usage_fault_exception, 1'b0);
			cmp_b(access_proceed, 1'b0);
			cmp_b(access_aligned, eal);
		end
	endtask
	task imm_forms;
		begin
			opr(1, 12'h47F, 0, 0, 0, 0, 2'b01, 32'hFF00_0000, 1, 1);
			opr(1, 12'h47F, 0, 0, 0, 0, 2'b00, 32'hFF00_0000, 1, 0);
			opr(1, 12'h0AB, 0, 0, 0, 1, 2'b01, 32'h0000_00AB, 1, 0);
			opr(1, 12'h1AB, 0, 0, 0, 1, 2'b01, 32'h00AB_00AB, 1, 0);
			opr(1, 12'h2AB, 0, 0, 0, 0, 2'b01, 32'hAB00_AB00, 0, 0);
			opr(1, 12'h3AB, 0, 0, 0, 0, 2'b01, 32'hABAB_ABAB, 0, 0);
		end
	endtask
	task shifts;
		begin
			opr(0, 0, S, 2, 1, 0, 2'b10, 32'hC000_0001, 1, 1);
			opr(0, 0, S, 2, 32, 0, 2'b10, 32'hFFFF_FFFF, 1, 1);
			opr(0, 0, S, 2, 0, 0, 2'b10, S, 0, 0);
			opr(0, 0, S, 1, 1, 0, 2'b10, 32'h4000_0001, 1, 1);
			opr(0, 0, S, 1, 32, 0, 2'b10, 32'h0000_0000, 1, 1);
			opr(0, 0, S, 1, 33, 1, 2'b10, 32'h0000_0000, 0, 1);
			opr(0, 0, S, 1, 1, 0, 2'b00, 32'h4000_0001, 1, 0);
			opr(0, 0, S, 0, 0, 1, 2'b10, S, 1, 0);
			opr(0, 0, S, 0, 1, 0, 2'b01, 32'h0000_0006, 1, 1);
			opr(0, 0, S, 0, 32, 0, 2'b10, 32'h0000_0000, 1, 1);
			opr(0, 0, S, 0, 33, 1, 2'b10, 32'h0000_0000, 0, 1);
			opr(0, 0, S, 3, 2, 0, 2'b10, 32'hE000_0000, 1, 1);
			opr(0, 0, S, 3, 32, 0, 2'b10, S, 1, 1);
			opr(0, 0, S, 3, 34, 0, 2'b01, 32'hE000_0000, 1, 1);
			opr(0, 0, S, 4, 0, 1, 2'b01, 32'hC000_0001, 1, 1);
			opr(0, 0, S, 4, 0, 0, 2'b00, 32'h4000_0001, 1, 0);
		end
	endtask
	task alignment;
		begin
			mchk(32'h3, 0, 0, 1, 1, 0);
			mchk(32'h1, 1, 0, 0, 0, 1);
			mchk(32'h1, 1, 1, 0, 0, 0);
			mchk(32'h6, 1, 0, 0, 1, 0);
			mchk(32'h2, 2, 1, 0, 0, 0);
			mchk(32'h2, 2, 1, 1, 0, 1);
			mchk(32'h4, 3, 0, 0, 1, 0);
			mchk(32'h1, 3, 0, 0, 0, 1);
			mchk(32'h8, 4, 0, 0, 1, 0);
			mchk(32'h2, 4, 0, 0, 0, 1);
		end
	endtask
	task complete_run;
		begin
			$display("checked %0d n_errors %0d", checked, n_errors);
			if (n_errors == 0 && checked > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	initial begin
		sys_clk = 0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial begin
		{srst, op_valid, op_use_imm, carry_flag, shift_insn_flags, logic_insn_flags} = 6'h21;
		{mem_valid, mem_unaligned_ok, unaligned_trap_enable} = 3'h0;
		{op_imm12, shift_source_register, mem_addr, shift_type, mem_size, shift_amount} = 90'h0;
		n_errors = 0;
		checked = 0;
		repeat (10) @(posedge sys_clk);
		srst <= 1'b0;
		#1;
		cmp_b(operand_valid, 1'b0);
		cmp_b(usage_fault_exception, 1'b0);
		imm_forms;
		shifts;
		alignment; // no program counter writes driven
		complete_run;
	end
endmodule // flexible_second_operand_shifter_align_check_tb
